// ===== pkg/rtcs_pkg.sv
package rtcs_pkg;
  // Timing base
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CHECK_INTERVAL_H = 24;
  localparam int SECONDS_PER_H = 3600;
  localparam int CHECK_SECONDS = CHECK_INTERVAL_H * SECONDS_PER_H;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CENTURY_HOURS = 6'h03;
  localparam logic [5:0] IDX_CALIBRATION_OUTPUT = 6'h08;
  localparam logic [5:0] IDX_WATCHDOG = 6'h09;
  localparam logic [5:0] IDX_FLAGS = 6'h0F;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;
  localparam logic [5:0] IDX_POWER_STATUS = 6'h13;

  // century_hours fields
  localparam int BIT_CENTURY_ENABLE = 7;
  localparam int BIT_CENTURY_TOGGLE = 6;
  // calibration_output fields
  localparam int BIT_OUTPUT_LEVEL = 7;
  localparam int BIT_FREQ_TEST = 6;
  // flags fields
  localparam int BIT_ALARM_FLAG = 6;
  localparam int BIT_BATTERY_LOW = 4;
  localparam int BIT_OSC_FAIL = 2;
  // control fields
  localparam int BIT_OSC_HALT = 0;
  localparam int BIT_ALARM_IRQ_EN = 1;
  localparam int BIT_SQUARE_WAVE_EN = 2;
  localparam int BIT_ALARM_BACKUP_EN = 3;
  localparam int BIT_OSC_FAIL_IRQ_EN = 4;
  localparam int BIT_POWER_DOWN_STAMP = 5;
  // Interrupt status and mask fields
  localparam int EV_CENTURY = 0;
  localparam int EV_BATTERY_LOW = 1;
  localparam int EV_OSC_FAIL = 2;
  localparam int EV_ALARM = 3;
  localparam int EV_COUNT = 4;

  // Reset values on first power-up
  localparam logic [7:0] RST_CENTURY_HOURS = 8'h00;
  localparam logic [7:0] RST_CALIBRATION = 8'h80;
  localparam logic [7:0] RST_WATCHDOG = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h21;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    RTCS_BUS_IDLE,
    RTCS_BUS_ANSWER
  } rtcs_bus_state_t;
endpackage

// ===== verilog/rtcs_status.sv
// Function
// - With century enable set, the century bit inverts at each rollover.
// - With century enable clear, the century bit holds at rollover.
// - Battery check at every power-up and once a day on main power.
// - A failing battery check sets the battery-low flag.
// - Battery-low flag holds until a later check passes.
// - Battery checks only happen while main supply is nominal.
// - Oscillator-fail sets on first power, oscillator stop, or halt bit.
// - Oscillator-fail stays set until software writes it zero.
// - Oscillator-fail with its enable pulls the pin active.
// - Only clearing enable or flag releases it; a flags read does not.
// - In static mode the pin follows the output level bit.
// - The pin is open drain; it only ever pulls low.
// - First power-up loads the documented control bit defaults.
// - Later power-up sets stamp, clears freq test and watchdog.
// - Other control bits keep their values at a later power-up.
// - Alarm match with enable, no square wave, sets flag and pin.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
module rtcs_status
  import rtcs_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int CHECK_SECONDS_P = CHECK_SECONDS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic main_power_good_in,
  input wire logic power_up_in,
  input wire logic battery_below_in,
  input wire logic osc_stopped_in,
  input wire logic century_rollover_in,
  input wire logic alarm_match_in,
  output logic multi_function_pin_in_unused_out,
  output logic multi_function_pin_out,
  output logic multi_function_pin_oe_out,
  output logic irq_out
);

  // Assertion timing for the whole block
  default clocking main_clk @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Register index match
  function automatic logic rtcs_hit(input logic [7:0] addr,
                                    input logic [5:0] idx);
    rtcs_hit = (addr[7:2] == idx);
  endfunction

  rtcs_bus_state_t bus_state_reg, bus_state_next;
  logic [31:0] readdata_reg, readdata_next;
  logic [7:0] century_reg, century_next;
  logic [7:0] cal_reg, cal_next;
  logic [7:0] wdog_reg, wdog_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic alarm_flag_reg, alarm_flag_next;
  logic battery_low_reg, battery_low_next;
  logic osc_fail_reg, osc_fail_next;
  logic [EV_COUNT-1:0] irq_stat_reg, irq_stat_next;
  logic [EV_COUNT-1:0] irq_mask_reg, irq_mask_next;
  logic mf_oe_reg, mf_oe_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [31:0] sec_cnt_reg, sec_cnt_next;
  logic first_reg;

  // Bus handshake: one wait cycle, then the answer edge
  wire req = avs_read_in | avs_write_in;
  wire accept = req & (bus_state_reg == RTCS_BUS_IDLE);
  wire done = req & (bus_state_reg == RTCS_BUS_ANSWER);
  wire wr_done = done & avs_write_in & avs_byteenable_in[0];
  wire rd_done = done & avs_read_in;
  wire [7:0] wdata = avs_writedata_in[7:0];
  wire wr_cent = wr_done & rtcs_hit(avs_address_in, IDX_CENTURY_HOURS);
  wire wr_cal = wr_done & rtcs_hit(avs_address_in, IDX_CALIBRATION_OUTPUT);
  wire wr_wdog = wr_done & rtcs_hit(avs_address_in, IDX_WATCHDOG);
  wire wr_flags = wr_done & rtcs_hit(avs_address_in, IDX_FLAGS);
  wire wr_ctrl = wr_done & rtcs_hit(avs_address_in, IDX_CONTROL);
  wire wr_mask = wr_done & rtcs_hit(avs_address_in, IDX_IRQ_MASK);
  wire rd_flags = rd_done & rtcs_hit(avs_address_in, IDX_FLAGS);
  wire rd_stat = rd_done & rtcs_hit(avs_address_in, IDX_IRQ_STATUS);

  // Named control bits
  wire century_enable = century_reg[BIT_CENTURY_ENABLE];
  wire century_toggle_bit = century_reg[BIT_CENTURY_TOGGLE];
  wire out_level = cal_reg[BIT_OUTPUT_LEVEL];
  wire freq_test = cal_reg[BIT_FREQ_TEST];
  wire osc_halt = ctrl_reg[BIT_OSC_HALT];
  wire alarm_irq_enable = ctrl_reg[BIT_ALARM_IRQ_EN];
  wire square_wave_enable = ctrl_reg[BIT_SQUARE_WAVE_EN];
  wire osc_fail_irq_enable = ctrl_reg[BIT_OSC_FAIL_IRQ_EN];
  wire wdog_set = (wdog_reg != RST_WATCHDOG);

  // Day timer runs on one-second ticks, only on main power
  wire tick = main_power_good_in &
              (tick_cnt_reg == 32'(TICK_CYCLES_P - 1));
  wire day_done = tick & (sec_cnt_reg == 32'(CHECK_SECONDS_P - 1));
  // First power-up (reset release) checks the battery as well
  wire check_now = main_power_good_in &
                   (first_reg | power_up_in | day_done);

  // Flag set, interrupt and pin drive conditions
  wire of_set = osc_stopped_in | osc_halt;
  wire of_irq = osc_fail_irq_enable & osc_fail_reg;
  wire alarm_irq = alarm_irq_enable & ~square_wave_enable &
                   alarm_flag_reg;
  wire static_mode = ~freq_test & ~alarm_irq_enable & ~square_wave_enable &
                     ~wdog_set;
  wire pin_low = static_mode ? (~out_level | of_irq)
                             : (of_irq | alarm_irq);
  wire [EV_COUNT-1:0] events = {alarm_match_in,
                                of_set & ~osc_fail_reg,
                                check_now & battery_below_in,
                                century_rollover_in};

  // Bus state and read data
  always_comb begin
    bus_state_next = bus_state_reg;
    readdata_next = readdata_reg;
    if (accept) begin
      bus_state_next = RTCS_BUS_ANSWER;
      readdata_next = READ_ZERO;
      if (rtcs_hit(avs_address_in, IDX_CENTURY_HOURS)) begin
        readdata_next[7:0] = century_reg;
      end else if (rtcs_hit(avs_address_in, IDX_CALIBRATION_OUTPUT)) begin
        readdata_next[7:0] = cal_reg;
      end else if (rtcs_hit(avs_address_in, IDX_WATCHDOG)) begin
        readdata_next[7:0] = wdog_reg;
      end else if (rtcs_hit(avs_address_in, IDX_FLAGS)) begin
        readdata_next[BIT_ALARM_FLAG] = alarm_flag_reg;
        readdata_next[BIT_BATTERY_LOW] = battery_low_reg;
        readdata_next[BIT_OSC_FAIL] = osc_fail_reg;
      end else if (rtcs_hit(avs_address_in, IDX_CONTROL)) begin
        readdata_next[7:0] = ctrl_reg;
      end else if (rtcs_hit(avs_address_in, IDX_IRQ_STATUS)) begin
        readdata_next[EV_COUNT-1:0] = irq_stat_reg;
      end else if (rtcs_hit(avs_address_in, IDX_IRQ_MASK)) begin
        readdata_next[EV_COUNT-1:0] = irq_mask_reg;
      end else if (rtcs_hit(avs_address_in, IDX_POWER_STATUS)) begin
        readdata_next[2:0] = {osc_stopped_in, battery_below_in,
                              main_power_good_in};
      end
    end else if (done) begin
      bus_state_next = RTCS_BUS_IDLE;
    end
  end

  // Century register
  always_comb begin
    century_next = century_reg;
    if (wr_cent) begin
      century_next = wdata;
    end
    if (century_rollover_in & century_enable) begin
      century_next[BIT_CENTURY_TOGGLE] = ~century_toggle_bit;
    end
  end

  // Calibration, watchdog and control; power-up beats a write
  always_comb begin
    cal_next = wr_cal ? wdata : cal_reg;
    wdog_next = wr_wdog ? wdata : wdog_reg;
    ctrl_next = wr_ctrl ? wdata : ctrl_reg;
    if (power_up_in) begin
      ctrl_next[BIT_POWER_DOWN_STAMP] = 1'b1;
      cal_next[BIT_FREQ_TEST] = 1'b0;
      wdog_next = RST_WATCHDOG;
    end
  end

  // Flags: hardware set wins over software clear
  always_comb begin
    alarm_flag_next = alarm_flag_reg;
    battery_low_next = battery_low_reg;
    osc_fail_next = osc_fail_reg;
    if (rd_flags) begin
      alarm_flag_next = 1'b0;
    end
    if (alarm_match_in) begin
      alarm_flag_next = 1'b1;
    end
    if (check_now) begin
      battery_low_next = battery_below_in;
    end
    if (wr_flags & ~wdata[BIT_OSC_FAIL]) begin
      osc_fail_next = 1'b0;
    end
    if (of_set) begin
      osc_fail_next = 1'b1;
    end
  end

  // Interrupt status, mask and pin drive
  always_comb begin
    irq_stat_next = rd_stat ? '0 : irq_stat_reg;
    irq_stat_next = irq_stat_next | events;
    irq_mask_next = wr_mask ? wdata[EV_COUNT-1:0] : irq_mask_reg;
    mf_oe_next = pin_low;
  end

  // Divider and day counter
  always_comb begin
    tick_cnt_next = tick_cnt_reg;
    sec_cnt_next = sec_cnt_reg;
    if (power_up_in | ~main_power_good_in) begin
      tick_cnt_next = '0;
      sec_cnt_next = '0;
    end else if (tick) begin
      tick_cnt_next = '0;
      sec_cnt_next = day_done ? '0 : sec_cnt_reg + 32'h0000_0001;
    end else begin
      tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
    end
  end

  // Bus registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_state_reg <= RTCS_BUS_IDLE;
      readdata_reg <= READ_ZERO;
    end else begin
      bus_state_reg <= bus_state_next;
      readdata_reg <= readdata_next;
    end
  end

  // Control registers; reset is the first power-up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      century_reg <= RST_CENTURY_HOURS;
      cal_reg <= RST_CALIBRATION;
      wdog_reg <= RST_WATCHDOG;
      ctrl_reg <= RST_CONTROL;
    end else begin
      century_reg <= century_next;
      cal_reg <= cal_next;
      wdog_reg <= wdog_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // Flag registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alarm_flag_reg <= 1'b0;
      battery_low_reg <= 1'b0;
      osc_fail_reg <= 1'b1;
    end else begin
      alarm_flag_reg <= alarm_flag_next;
      battery_low_reg <= battery_low_next;
      osc_fail_reg <= osc_fail_next;
    end
  end

  // Interrupt and pin registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= RST_IRQ_MASK;
      mf_oe_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      mf_oe_reg <= mf_oe_next;
    end
  end

  // Timer registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= '0;
      sec_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      sec_cnt_reg <= sec_cnt_next;
    end
  end

  // Outputs; the pin output value is always low
  assign avs_waitrequest_out = req & (bus_state_reg != RTCS_BUS_ANSWER);
  assign avs_readdata_out = readdata_reg;
  assign multi_function_pin_out = 1'b0;
  assign multi_function_pin_oe_out = mf_oe_reg;
  assign multi_function_pin_in_unused_out = 1'b0;
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // First cycle after reset release; starts the power-up battery check
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  sequence s_flags_read_held;
    rd_flags && of_irq && !wr_ctrl && !wr_flags;
  endsequence

  sequence s_alarm_armed;
    alarm_match_in && alarm_irq_enable && !square_wave_enable &&
      !wr_ctrl && !rd_flags;
  endsequence

  a_century_toggle: assert property (
    century_rollover_in && century_enable |=>
      century_toggle_bit != $past(century_toggle_bit))
    else $error("century bit did not invert at rollover");

  a_century_hold: assert property (
    century_rollover_in && !century_enable && !wr_cent |=>
      $stable(century_toggle_bit))
    else $error("century bit changed with enable clear");

  a_batt_power_up: assert property (
    power_up_in && main_power_good_in |-> check_now)
    else $error("no battery check at power-up");

  a_batt_result: assert property (
    check_now |=> battery_low_reg == $past(battery_below_in))
    else $error("battery flag does not match check result");

  a_batt_hold: assert property (
    !check_now |=> $stable(battery_low_reg))
    else $error("battery flag moved without a check");

  a_batt_on_main: assert property (
    check_now |-> main_power_good_in)
    else $error("battery check without main power");

  a_osc_fail_set: assert property (
    osc_stopped_in || osc_halt |=> osc_fail_reg)
    else $error("oscillator fail flag not set");

  a_osc_fail_sticky: assert property (
    osc_fail_reg && !wr_flags |=> osc_fail_reg)
    else $error("oscillator fail flag cleared without write");

  a_osc_irq_pin: assert property (
    of_irq |=> multi_function_pin_oe_out)
    else $error("oscillator fail interrupt not on pin");

  a_read_no_release: assert property (
    s_flags_read_held ##1 1'b1 |-> ##1 multi_function_pin_oe_out)
    else $error("flags read released oscillator interrupt");

  a_static_level: assert property (
    static_mode && !of_irq |=> multi_function_pin_oe_out ==
      !$past(out_level))
    else $error("static pin does not follow output level");

  a_open_drain: assert property (
    multi_function_pin_out == 1'b0)
    else $error("pin driven high");

  a_first_defaults: assert property (
    first_reg |-> osc_halt && out_level && osc_fail_reg &&
      ctrl_reg[BIT_POWER_DOWN_STAMP] && !alarm_irq_enable &&
      !square_wave_enable && !osc_fail_irq_enable && !freq_test &&
      !wdog_set && !ctrl_reg[BIT_ALARM_BACKUP_EN])
    else $error("first power-up defaults wrong");

  a_later_power_up: assert property (
    power_up_in |=> ctrl_reg[BIT_POWER_DOWN_STAMP] && !freq_test &&
      !wdog_set && osc_halt == $past(osc_halt) &&
      alarm_irq_enable == $past(alarm_irq_enable))
    else $error("power-up defaults wrong");

  a_alarm_pin: assert property (
    s_alarm_armed |=> alarm_flag_reg ##1
      (multi_function_pin_oe_out || rd_flags || $past(wr_ctrl)))
    else $error("alarm did not reach pin");

  a_any_pending: assert property (
    !static_mode && (of_irq || alarm_irq) |=> multi_function_pin_oe_out)
    else $error("pending interrupt not on pin");

endmodule

// ===== verif/rtcs_host.sv
// Host controller model driving the register bus as an Avalon master
module rtcs_host
  import rtcs_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic avs_waitrequest_in,
  input wire logic [31:0] avs_readdata_in,
  output logic [7:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [3:0] avs_byteenable_out,
  output logic [31:0] avs_writedata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    avs_address_out <= 8'h00;
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
    avs_byteenable_out <= 4'h1;
    avs_writedata_out <= 32'h0000_0000;
  end

  // Write one register; held until waitrequest is sampled low
  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    @(posedge clk_in);
    avs_address_out <= {idx, 2'b00};
    avs_writedata_out <= {24'h000000, val};
    avs_write_out <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_in !== 1'b0);
    avs_write_out <= 1'b0;
  endtask

  // Read one register; data taken at the answer edge
  task automatic rd(input logic [5:0] idx, output logic [31:0] val);
    @(posedge clk_in);
    avs_address_out <= {idx, 2'b00};
    avs_read_out <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_in !== 1'b0);
    val = avs_readdata_in;
    avs_read_out <= 1'b0;
  endtask

  // Let the oscillator run four seconds before clearing the fail flag
  task automatic clear_osc_fail();
    repeat (4 * TICK_CYCLES_P + 1) @(posedge clk_in);
    wr(IDX_FLAGS, 8'h00);
  endtask

  // Restart the oscillator: halt high, then low at once
  task automatic restart_osc(input logic [7:0] ctrl);
    wr(IDX_CONTROL, ctrl | 8'h01);
    wr(IDX_CONTROL, ctrl & 8'hFE);
  endtask
endmodule

// ===== verif/rtcs_status_bench.sv
// Self-checking bench for the status and control block
module rtcs_status_bench
  import rtcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam int DAY = 3 * TK;
  logic clk_in, rst_n_in;
  logic [7:0] adr;
  logic rd_s, wr_s, wait_s;
  logic [3:0] be;
  logic [31:0] wdat, rdat, d;
  logic pwr_good, pwr_up, bat_low, osc_stop, roll, alarm;
  logic pin_unused, pin, pin_oe, irq;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  rtcs_status #(.TICK_CYCLES_P(TK), .CHECK_SECONDS_P(3)) i_rtcs_status (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_byteenable_in(be),
    .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_s), .main_power_good_in(pwr_good),
    .power_up_in(pwr_up), .battery_below_in(bat_low),
    .osc_stopped_in(osc_stop), .century_rollover_in(roll),
    .alarm_match_in(alarm), .multi_function_pin_in_unused_out(pin_unused),
    .multi_function_pin_out(pin), .multi_function_pin_oe_out(pin_oe),
    .irq_out(irq));

  rtcs_host #(.TICK_CYCLES_P(TK)) i_rtcs_host (
    .clk_in(clk_in), .avs_waitrequest_in(wait_s), .avs_readdata_in(rdat),
    .avs_address_out(adr), .avs_read_out(rd_s), .avs_write_out(wr_s),
    .avs_byteenable_out(be), .avs_writedata_out(wdat));

  // Clock at 125 MHz
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Level outputs are judged mid-cycle after the two-edge latency
  task automatic pin_is(input logic v);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk({31'h0, pin_oe}, {31'h0, v});
    chk({31'h0, pin}, 32'h0);
    chk({31'h0, pin_unused}, 32'h0);
  endtask

  task automatic t_defaults();
    i_rtcs_host.rd(IDX_CALIBRATION_OUTPUT, d);
    chk(d, 32'h80);
    i_rtcs_host.rd(IDX_CONTROL, d);
    chk(d, 32'h21);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h14, 32'h14);
    bat_low <= 1'b0;
    i_rtcs_host.rd(IDX_WATCHDOG, d);
    chk(d, 32'h00);
    i_rtcs_host.rd(6'h1F, d);
    chk(d, 32'h00);
    pin_is(1'b0);
  endtask

  task automatic t_level();
    i_rtcs_host.wr(IDX_CALIBRATION_OUTPUT, 8'h00);
    pin_is(1'b1);
    i_rtcs_host.wr(IDX_CALIBRATION_OUTPUT, 8'h80);
    pin_is(1'b0);
  endtask

  // Each row: written century byte, expected after one rollover
  task automatic t_century();
    logic [7:0] w [3] = '{8'h80, 8'hC0, 8'h40};
    logic [7:0] e [3] = '{8'hC0, 8'h80, 8'h40};
    for (int i = 0; i < 3; i++) begin
      i_rtcs_host.wr(IDX_CENTURY_HOURS, w[i]);
      @(posedge clk_in);
      roll <= 1'b1;
      @(posedge clk_in);
      roll <= 1'b0;
      i_rtcs_host.rd(IDX_CENTURY_HOURS, d);
      chk(d, {24'h0, e[i]});
    end
  endtask

  task automatic stop_osc();
    @(posedge clk_in);
    osc_stop <= 1'b1;
    @(posedge clk_in);
    osc_stop <= 1'b0;
  endtask

  task automatic t_osc();
    i_rtcs_host.wr(IDX_CONTROL, 8'h00);
    i_rtcs_host.clear_osc_fail();
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h04, 32'h00);
    i_rtcs_host.wr(IDX_CONTROL, 8'h10);
    pin_is(1'b0);
    stop_osc();
    pin_is(1'b1);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h04, 32'h04);
    pin_is(1'b1);
    i_rtcs_host.wr(IDX_FLAGS, 8'h04);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h04, 32'h04);
    i_rtcs_host.wr(IDX_CONTROL, 8'h00);
    pin_is(1'b0);
    i_rtcs_host.clear_osc_fail();
    i_rtcs_host.restart_osc(8'h10);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h04, 32'h04);
    i_rtcs_host.clear_osc_fail();
    pin_is(1'b0);
    i_rtcs_host.wr(IDX_CONTROL, 8'h00);
  endtask

  task automatic t_alarm();
    i_rtcs_host.wr(IDX_CONTROL, 8'h02);
    @(posedge clk_in);
    alarm <= 1'b1;
    @(posedge clk_in);
    alarm <= 1'b0;
    pin_is(1'b1);
    chk({31'h0, irq}, 32'h0);
    i_rtcs_host.wr(IDX_IRQ_MASK, 8'h08);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h1);
    i_rtcs_host.rd(IDX_IRQ_STATUS, d);
    chk(d & 32'h08, 32'h08);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h0);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h40, 32'h40);
    pin_is(1'b0);
    i_rtcs_host.wr(IDX_CONTROL, 8'h00);
  endtask

  task automatic t_battery();
    @(posedge clk_in);
    bat_low <= 1'b1;
    repeat (DAY + TK) @(posedge clk_in);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h10, 32'h10);
    pwr_good <= 1'b0;
    bat_low <= 1'b0;
    repeat (3 * DAY) @(posedge clk_in);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h10, 32'h10);
    pwr_good <= 1'b1;
    repeat (DAY + TK) @(posedge clk_in);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h10, 32'h00);
    pwr_good <= 1'b0;
    bat_low <= 1'b1;
    repeat (3 * DAY) @(posedge clk_in);
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h10, 32'h00);
  endtask

  task automatic t_power_up();
    i_rtcs_host.wr(IDX_CALIBRATION_OUTPUT, 8'hC0);
    i_rtcs_host.wr(IDX_WATCHDOG, 8'h05);
    i_rtcs_host.wr(IDX_CONTROL, 8'h1A);
    @(posedge clk_in);
    pwr_good <= 1'b1;
    pwr_up <= 1'b1;
    @(posedge clk_in);
    pwr_up <= 1'b0;
    i_rtcs_host.rd(IDX_FLAGS, d);
    chk(d & 32'h10, 32'h10);
    i_rtcs_host.rd(IDX_CONTROL, d);
    chk(d, 32'h3A);
    i_rtcs_host.rd(IDX_CALIBRATION_OUTPUT, d);
    chk(d, 32'h80);
    i_rtcs_host.rd(IDX_WATCHDOG, d);
    chk(d, 32'h00);
    i_rtcs_host.rd(IDX_POWER_STATUS, d);
    chk(d, 32'h03);
  endtask

  // Main sequence
  initial begin
    rst_n_in <= 1'b0;
    pwr_good <= 1'b1;
    pwr_up <= 1'b0;
    bat_low <= 1'b1;
    osc_stop <= 1'b0;
    roll <= 1'b0;
    alarm <= 1'b0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_defaults();
    t_level();
    t_century();
    t_osc();
    t_alarm();
    t_battery();
    t_power_up();
    complete_run();
  end
endmodule
